//--- imgr_pkg.sv
// constants and field layout of the input mixer gain register bank
// Contract
// [RULE1] left mixer bit 8 unmutes preamp-B path
// [RULE2] left mixer bit 7 adds 30dB on preamp-B
// [RULE3] left mixer bit 5 unmutes preamp-A path
// [RULE4] left mixer bit 4 adds 30dB on preamp-A
// [RULE5] left mixer bits 2:0 set loop gain
// [RULE6] left aux bits 8:6 set line-2 gain
// [RULE7] left aux bits 5:3 set voice-to-mux gain
// [RULE8] left aux bits 2:0 set voice-to-mixer gain
// [RULE9] right mixer bit 8 unmutes preamp-B path
// [RULE10] right mixer bit 7 adds 30dB on preamp-B
// [RULE11] right mixer bit 5 unmutes preamp-A path
// [RULE12] right mixer bit 4 adds 30dB on preamp-A
// [RULE13] right mixer bits 2:0 set loop gain
// [RULE14] right aux bits 8:6 set line-2 gain
// [RULE15] right aux bits 5:3 set voice-to-mux gain
// [RULE16] right aux bits 2:0 set voice-to-mixer gain
// [RULE17] software matches left voice gains in voice mode
// [RULE18] software matches right voice gains in voice mode
// [RULE19] software avoids gain changes while paths active
// [RULE20] source select picks mixer, voice or differential
// [RULE21] decoded selects follow stored fields after write
package imgr_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int REG_W = 9;
  localparam int SEL_REG_W = 4;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_ADC_SOURCE_SELECT = 8'h27;
  localparam logic [7:0] ADDR_LEFT_MIXER_PGA_LOOP_GAIN = 8'h29;
  localparam logic [7:0] ADDR_RIGHT_MIXER_PGA_LOOP_GAIN = 8'h2a;
  localparam logic [7:0] ADDR_LEFT_MIXER_LINE_VOICE_GAIN = 8'h2b;
  localparam logic [7:0] ADDR_RIGHT_MIXER_LINE_VOICE_GAIN = 8'h2c;
  localparam logic [7:0] ADDR_VOICE_GAIN_STATUS = 8'h2d;

  // ==========================================================
  // reset values
  localparam logic [8:0] RST_GAIN_REG = 9'h000;
  localparam logic [3:0] RST_SEL_REG = 4'h0;
  localparam logic [15:0] RDATA_IDLE = 16'h0000;

  // ==========================================================
  // writable bits (bits 6 and 3 of the mixer words are reserved)
  localparam logic [8:0] MASK_MIXER_REG = 9'h1b7;
  localparam logic [8:0] MASK_AUX_REG = 9'h1ff;

  // ==========================================================
  // field positions
  localparam int BIT_PGAB_UNMUTE = 8;
  localparam int BIT_PGAB_BOOST = 7;
  localparam int BIT_PGAA_UNMUTE = 5;
  localparam int BIT_PGAA_BOOST = 4;
  localparam int LSB_LOOP_GAIN = 0;
  localparam int LSB_LINE2_GAIN = 6;
  localparam int LSB_VOICE_MUX_GAIN = 3;
  localparam int LSB_VOICE_MIX_GAIN = 0;
  localparam int LSB_LEFT_SRC_SEL = 2;
  localparam int LSB_RIGHT_SRC_SEL = 0;
  localparam int CODE_W = 3;
  localparam int GAIN_SEL_W = 7;
  localparam int N_CODES = 8;

  // ==========================================================
  // adc source multiplexer encodings
  localparam logic [1:0] SRC_INPUT_MIXER = 2'h0;
  localparam logic [1:0] SRC_VOICE = 2'h1;
  localparam logic [1:0] SRC_DIFF_PREAMP = 2'h2;
  localparam int SRC_IDX_MIXER = 0;
  localparam int SRC_IDX_VOICE = 1;
  localparam int SRC_IDX_DIFF = 2;

  // all flops of the bank
  typedef struct packed {
    logic [8:0] mix_l;
    logic [8:0] mix_r;
    logic [8:0] aux_l;
    logic [8:0] aux_r;
    logic [3:0] src_sel;
    logic [15:0] rdata;
    logic [N_CODES-1:0][GAIN_SEL_W-1:0] gain_sel;
    logic [2:0] src_mux_l;
    logic [2:0] src_mux_r;
    logic [1:0] voice_mismatch;
  } imgr_state_s;

endpackage

//--- imgr_top.sv
// input mixer gain register bank with decoded analogue selects
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module imgr_top
  import imgr_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  // left path controls
  output logic left_pgab_path_unmute_out,
  output logic left_pgab_path_boost_out,
  output logic left_pgaa_path_unmute_out,
  output logic left_pgaa_path_boost_out,
  output logic [GAIN_SEL_W-1:0] left_loop_gain_sel_out,
  output logic [GAIN_SEL_W-1:0] left_line2_gain_sel_out,
  output logic [GAIN_SEL_W-1:0] left_voice_to_mux_gain_sel_out,
  output logic [GAIN_SEL_W-1:0] left_voice_to_mixer_gain_sel_out,
  output logic [2:0] left_adc_source_mux_out,
  // right path controls
  output logic right_pgab_path_unmute_out,
  output logic right_pgab_path_boost_out,
  output logic right_pgaa_path_unmute_out,
  output logic right_pgaa_path_boost_out,
  output logic [GAIN_SEL_W-1:0] right_loop_gain_sel_out,
  output logic [GAIN_SEL_W-1:0] right_line2_gain_sel_out,
  output logic [GAIN_SEL_W-1:0] right_voice_to_mux_gain_sel_out,
  output logic [GAIN_SEL_W-1:0] right_voice_to_mixer_gain_sel_out,
  output logic [2:0] right_adc_source_mux_out,
  // voice gain pair disagreement, bit 0 left, bit 1 right
  output logic [1:0] voice_gain_mismatch_out
);

  // ==========================================================
  // state
  imgr_state_s st;
  imgr_state_s next_st;

  // ==========================================================
  // write path: next register values
  logic wr_mix_l;
  logic wr_mix_r;
  logic wr_aux_l;
  logic wr_aux_r;
  logic wr_sel;
  logic [8:0] mix_l_nx;
  logic [8:0] mix_r_nx;
  logic [8:0] aux_l_nx;
  logic [8:0] aux_r_nx;
  logic [3:0] sel_nx;

  // address decode, qualified by the write strobe
  assign wr_mix_l = wr_in && (addr_in == ADDR_LEFT_MIXER_PGA_LOOP_GAIN);
  assign wr_mix_r = wr_in && (addr_in == ADDR_RIGHT_MIXER_PGA_LOOP_GAIN);
  assign wr_aux_l = wr_in && (addr_in == ADDR_LEFT_MIXER_LINE_VOICE_GAIN);
  assign wr_aux_r = wr_in && (addr_in == ADDR_RIGHT_MIXER_LINE_VOICE_GAIN);
  assign wr_sel = wr_in && (addr_in == ADDR_ADC_SOURCE_SELECT);

  // reserved bits are dropped on the way in so they always read zero
  assign mix_l_nx = wr_mix_l ? (wdata_in[REG_W-1:0] & MASK_MIXER_REG) : st.mix_l; // [RULE1] [RULE2] [RULE3] [RULE4]
  assign mix_r_nx = wr_mix_r ? (wdata_in[REG_W-1:0] & MASK_MIXER_REG) : st.mix_r; // [RULE9] [RULE10] [RULE11] [RULE12]
  assign aux_l_nx = wr_aux_l ? (wdata_in[REG_W-1:0] & MASK_AUX_REG) : st.aux_l;
  assign aux_r_nx = wr_aux_r ? (wdata_in[REG_W-1:0] & MASK_AUX_REG) : st.aux_r;
  assign sel_nx = wr_sel ? wdata_in[SEL_REG_W-1:0] : st.src_sel;

  // ==========================================================
  // gain code extraction, decoded from next values so that the
  // analogue selects change on the same edge as the stored word
  logic [N_CODES-1:0][CODE_W-1:0] code_nx;
  logic [N_CODES-1:0][GAIN_SEL_W-1:0] dec_nx;

  assign code_nx[0] = mix_l_nx[LSB_LOOP_GAIN +: CODE_W]; // [RULE5]
  assign code_nx[1] = aux_l_nx[LSB_LINE2_GAIN +: CODE_W]; // [RULE6]
  assign code_nx[2] = aux_l_nx[LSB_VOICE_MUX_GAIN +: CODE_W]; // [RULE7]
  assign code_nx[3] = aux_l_nx[LSB_VOICE_MIX_GAIN +: CODE_W]; // [RULE8]
  assign code_nx[4] = mix_r_nx[LSB_LOOP_GAIN +: CODE_W]; // [RULE13]
  assign code_nx[5] = aux_r_nx[LSB_LINE2_GAIN +: CODE_W]; // [RULE14]
  assign code_nx[6] = aux_r_nx[LSB_VOICE_MUX_GAIN +: CODE_W]; // [RULE15]
  assign code_nx[7] = aux_r_nx[LSB_VOICE_MIX_GAIN +: CODE_W]; // [RULE16]

  // one-hot step select: code k lights bit k-1, code zero lights none (mute)
  genvar gi;
  genvar gk;
  generate
    for (gi = 0; gi < N_CODES; gi++) begin : g_code
      for (gk = 0; gk < GAIN_SEL_W; gk++) begin : g_step
        assign dec_nx[gi][gk] = (code_nx[gi] == CODE_W'(gk + 1)); // [RULE21]
      end
    end
  endgenerate

  // ==========================================================
  // adc source decode; the reserved code selects nothing
  logic [1:0] src_l_nx;
  logic [1:0] src_r_nx;
  logic [2:0] mux_l_nx;
  logic [2:0] mux_r_nx;

  assign src_l_nx = sel_nx[LSB_LEFT_SRC_SEL +: 2];
  assign src_r_nx = sel_nx[LSB_RIGHT_SRC_SEL +: 2];

  // one-hot per side: mixer, voice, differential preamp pair
  always_comb begin
    mux_l_nx = 3'h0;
    mux_r_nx = 3'h0;
    case (src_l_nx)
      SRC_INPUT_MIXER: mux_l_nx[SRC_IDX_MIXER] = 1'b1; // [RULE20]
      SRC_VOICE: mux_l_nx[SRC_IDX_VOICE] = 1'b1;
      SRC_DIFF_PREAMP: mux_l_nx[SRC_IDX_DIFF] = 1'b1;
      default: mux_l_nx = 3'h0;
    endcase
    case (src_r_nx)
      SRC_INPUT_MIXER: mux_r_nx[SRC_IDX_MIXER] = 1'b1; // [RULE20]
      SRC_VOICE: mux_r_nx[SRC_IDX_VOICE] = 1'b1;
      SRC_DIFF_PREAMP: mux_r_nx[SRC_IDX_DIFF] = 1'b1;
      default: mux_r_nx = 3'h0;
    endcase
  end

  // ==========================================================
  // voice pair check; hardware only reports it, software must fix it
  logic [1:0] mismatch_nx;

  assign mismatch_nx[0] = (src_l_nx == SRC_VOICE) && (code_nx[2] != code_nx[3]); // [RULE17]
  assign mismatch_nx[1] = (src_r_nx == SRC_VOICE) && (code_nx[6] != code_nx[7]); // [RULE18]

  // ==========================================================
  // read mux, answered from the values before any same-cycle write
  logic [DATA_W-1:0] rd_word;

  always_comb begin
    rd_word = RDATA_IDLE;
    case (addr_in)
      ADDR_LEFT_MIXER_PGA_LOOP_GAIN: rd_word = {7'h00, st.mix_l};
      ADDR_RIGHT_MIXER_PGA_LOOP_GAIN: rd_word = {7'h00, st.mix_r};
      ADDR_LEFT_MIXER_LINE_VOICE_GAIN: rd_word = {7'h00, st.aux_l};
      ADDR_RIGHT_MIXER_LINE_VOICE_GAIN: rd_word = {7'h00, st.aux_r};
      ADDR_ADC_SOURCE_SELECT: rd_word = {12'h000, st.src_sel};
      ADDR_VOICE_GAIN_STATUS: rd_word = {14'h0000, st.voice_mismatch};
      default: rd_word = RDATA_IDLE;
    endcase
  end

  // ==========================================================
  // next state; gain fields are static, so no zero-cross timing is
  // attempted here and a change mid-stream may pop
  always_comb begin
    next_st = st;
    next_st.mix_l = mix_l_nx;
    next_st.mix_r = mix_r_nx;
    next_st.aux_l = aux_l_nx;
    next_st.aux_r = aux_r_nx;
    next_st.src_sel = sel_nx;
    next_st.gain_sel = dec_nx; // [RULE21]
    next_st.src_mux_l = mux_l_nx;
    next_st.src_mux_r = mux_r_nx;
    next_st.voice_mismatch = mismatch_nx;
    // read data stands one cycle only
    next_st.rdata = rd_in ? rd_word : RDATA_IDLE;
  end

  // state register; mute-everything reset is implied by zero codes
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.mix_l <= RST_GAIN_REG;
      st.mix_r <= RST_GAIN_REG;
      st.aux_l <= RST_GAIN_REG;
      st.aux_r <= RST_GAIN_REG;
      st.src_sel <= RST_SEL_REG;
      st.rdata <= RDATA_IDLE;
      st.gain_sel <= '0;
      st.src_mux_l <= 3'h1;
      st.src_mux_r <= 3'h1;
      st.voice_mismatch <= 2'h0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs, each straight from a flop
  assign rdata_out = st.rdata;
  assign left_pgab_path_unmute_out = st.mix_l[BIT_PGAB_UNMUTE]; // [RULE1]
  assign left_pgab_path_boost_out = st.mix_l[BIT_PGAB_BOOST]; // [RULE2]
  assign left_pgaa_path_unmute_out = st.mix_l[BIT_PGAA_UNMUTE]; // [RULE3]
  assign left_pgaa_path_boost_out = st.mix_l[BIT_PGAA_BOOST]; // [RULE4]
  assign right_pgab_path_unmute_out = st.mix_r[BIT_PGAB_UNMUTE]; // [RULE9]
  assign right_pgab_path_boost_out = st.mix_r[BIT_PGAB_BOOST]; // [RULE10]
  assign right_pgaa_path_unmute_out = st.mix_r[BIT_PGAA_UNMUTE]; // [RULE11]
  assign right_pgaa_path_boost_out = st.mix_r[BIT_PGAA_BOOST]; // [RULE12]
  assign left_loop_gain_sel_out = st.gain_sel[0];
  assign left_line2_gain_sel_out = st.gain_sel[1];
  assign left_voice_to_mux_gain_sel_out = st.gain_sel[2];
  assign left_voice_to_mixer_gain_sel_out = st.gain_sel[3];
  assign right_loop_gain_sel_out = st.gain_sel[4];
  assign right_line2_gain_sel_out = st.gain_sel[5];
  assign right_voice_to_mux_gain_sel_out = st.gain_sel[6];
  assign right_voice_to_mixer_gain_sel_out = st.gain_sel[7];
  assign left_adc_source_mux_out = st.src_mux_l;
  assign right_adc_source_mux_out = st.src_mux_r;
  assign voice_gain_mismatch_out = st.voice_mismatch;

endmodule // imgr_top

//--- imgr_monitor.sv
// assertion checker for the input mixer gain register bank
`timescale 1ns/1ps
module imgr_monitor
  import imgr_pkg::*;
(
  // clock, reset, register port
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  // watched controls
  input wire logic left_pgab_path_unmute_out,
  input wire logic right_pgaa_path_boost_out,
  input wire logic [GAIN_SEL_W-1:0] left_loop_gain_sel_out,
  input wire logic [GAIN_SEL_W-1:0] right_line2_gain_sel_out,
  input wire logic [GAIN_SEL_W-1:0] left_voice_to_mux_gain_sel_out,
  input wire logic [2:0] left_adc_source_mux_out
);
  // ==========================================================
  // helpers
  logic wt;
  assign wt = ce_in & wr_in;
  // code 0 mutes, so no select line may be high
  function automatic logic [6:0] oh(input logic [2:0] c);
    return (c == 3'h0) ? 7'h00 : 7'h01 << (c - 3'h1);
  endfunction
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // assertions
  chk_rdata_idle: assert property (ce_in && !rd_in |=> rdata_out == 16'h0000)
    else $error("read data not idle");
  chk_pgab_unmute: assert property (wt && addr_in == ADDR_LEFT_MIXER_PGA_LOOP_GAIN
    |=> left_pgab_path_unmute_out == $past(wdata_in[8])) else $error("left preamp-b unmute wrong");
  chk_pgaa_boost: assert property (wt && addr_in == ADDR_RIGHT_MIXER_PGA_LOOP_GAIN
    |=> right_pgaa_path_boost_out == $past(wdata_in[4])) else $error("right preamp-a boost wrong");
  chk_loop_sel: assert property (wt && addr_in == ADDR_LEFT_MIXER_PGA_LOOP_GAIN
    |=> left_loop_gain_sel_out == oh($past(wdata_in[2:0]))) else $error("left loop select wrong");
  chk_line2_sel: assert property (wt && addr_in == ADDR_RIGHT_MIXER_LINE_VOICE_GAIN
    |=> right_line2_gain_sel_out == oh($past(wdata_in[8:6]))) else $error("right line2 select wrong");
  chk_voice_mux: assert property (wt && addr_in == ADDR_LEFT_MIXER_LINE_VOICE_GAIN
    |=> left_voice_to_mux_gain_sel_out == oh($past(wdata_in[5:3]))) else $error("voice mux select wrong");
  chk_src_mux: assert property (wt && addr_in == ADDR_ADC_SOURCE_SELECT ##1 $past(wdata_in[3:2]) != 2'h3
    |-> left_adc_source_mux_out == 3'h1 << $past(wdata_in[3:2])) else $error("left source select wrong");
  chk_ctrl_hold: assert property (!wt |=> $stable({left_pgab_path_unmute_out, right_pgaa_path_boost_out,
    left_loop_gain_sel_out, right_line2_gain_sel_out, left_adc_source_mux_out})) else $error("control moved");
  // main scenarios reached
  cov_mix_write: cover property (wt && addr_in == ADDR_LEFT_MIXER_PGA_LOOP_GAIN);
  cov_read_data: cover property (ce_in && rd_in ##1 rdata_out != 16'h0000);
  cov_src_resv: cover property (wt && addr_in == ADDR_ADC_SOURCE_SELECT && wdata_in[3:2] == 2'h3);
endmodule // imgr_monitor

//--- test_input_mixer_gain_registers.sv
// self-checking bench for the input mixer gain register bank
`timescale 1ns/1ps
module test_input_mixer_gain_registers;
  import imgr_pkg::*;
  // ==========================================================
  // stimulus, observation and model state
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  wire [71:0] ctl;
  logic [8:0] mdl [39:45];
  logic [7:0] adr [8] = '{8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h30};
  int bad_count = 0;
  int checks_done = 0;
  int seed = 39440;
  always #5 mclk_in = ~mclk_in;
  imgr_top i_imgr_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .left_pgab_path_unmute_out(ctl[71]), .left_pgab_path_boost_out(ctl[70]),
    .left_pgaa_path_unmute_out(ctl[69]), .left_pgaa_path_boost_out(ctl[68]),
    .left_loop_gain_sel_out(ctl[67:61]), .left_line2_gain_sel_out(ctl[60:54]),
    .left_voice_to_mux_gain_sel_out(ctl[53:47]), .left_voice_to_mixer_gain_sel_out(ctl[46:40]),
    .left_adc_source_mux_out(ctl[39:37]), .right_pgab_path_unmute_out(ctl[36]),
    .right_pgab_path_boost_out(ctl[35]), .right_pgaa_path_unmute_out(ctl[34]),
    .right_pgaa_path_boost_out(ctl[33]), .right_loop_gain_sel_out(ctl[32:26]),
    .right_line2_gain_sel_out(ctl[25:19]), .right_voice_to_mux_gain_sel_out(ctl[18:12]),
    .right_voice_to_mixer_gain_sel_out(ctl[11:5]), .right_adc_source_mux_out(ctl[4:2]),
    .voice_gain_mismatch_out(ctl[1:0]));
  // ==========================================================
  // model of the decoded controls
  function automatic logic [6:0] oh(input logic [2:0] c);
    return (c == 3'h0) ? 7'h00 : 7'h01 << (c - 3'h1);
  endfunction
  function automatic logic [34:0] side(input logic [8:0] m, input logic [8:0] x, input logic [1:0] s);
    return {m[8], m[7], m[5], m[4], oh(m[2:0]), oh(x[8:6]), oh(x[5:3]), oh(x[2:0]),
      (s == 2'h3) ? 3'h0 : 3'h1 << s};
  endfunction
  function automatic logic [71:0] expc();
    logic [1:0] mm;
    mm[0] = mdl[39][3:2] == 2'h1 && mdl[43][5:3] != mdl[43][2:0];
    mm[1] = mdl[39][1:0] == 2'h1 && mdl[44][5:3] != mdl[44][2:0];
    return {side(mdl[41], mdl[43], mdl[39][3:2]), side(mdl[42], mdl[44], mdl[39][1:0]), mm};
  endfunction
  // reserved bits 6 and 3 and the high bits set, to see them dropped
  function automatic logic [15:0] mixd(input logic [2:0] k);
    return {7'h7f, k[0], k[1], 1'b1, k[2], k[0], 1'b1, k};
  endfunction
  // ==========================================================
  // compares and bus cycles
  task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t read got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    if (ce_in === 1'b1 && a >= 8'h27 && a <= 8'h2c && a != 8'h28) begin
      mdl[a] = (a == 8'h27) ? {5'h00, d[3:0]} : (a < 8'h2b) ? d[8:0] & MASK_MIXER_REG : d[8:0];
    end
    #1 cmp(ctl, expc());
  endtask
  task automatic rd(input logic [7:0] a);
    logic [71:0] e;
    e = expc();
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 cmp_rd(rdata_out, (a == 8'h2d) ? e[1:0] : (a >= 8'h27 && a <= 8'h2c) ? mdl[a] : 16'h0000);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    $display("Error %0t watchdog expired", $time);
    tally_and_finish;
  end
  // ==========================================================
  // main sequence
  initial begin
    foreach (mdl[i]) mdl[i] = 9'h000;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1 cmp(ctl, expc());
    for (int a = 8'h26; a <= 8'h2e; a++) rd(a[7:0]);
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin // each code set once, then held while checked
      wr(8'h29, mixd(k[2:0]));
      wr(8'h2a, mixd(~k[2:0]));
      wr(8'h2b, {7'h7f, k[2:0], k[2:0], ~k[2:0]});
      wr(8'h2c, {7'h00, ~k[2:0], k[2:0], k[2:0]});
      wr(8'h27, {12'hfff, k[1:0], ~k[1:0]});
      rd(8'h29);
      rd(8'h2d);
    end
    $display("test every code done");
    ce_in <= 1'b0;
    wr(8'h29, 16'h01b5);
    ce_in <= 1'b1;
    wr(8'h2d, 16'hffff);
    rd(8'h29);
    $display("test refused writes done");
    repeat (60) begin
      wr(adr[$random(seed) & 7], $random(seed));
      rd(adr[$random(seed) & 7]);
    end
    $display("test random traffic done");
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    foreach (mdl[i]) mdl[i] = 9'h000;
    #1 cmp(ctl, expc());
    rd(8'h2b);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule // test_input_mixer_gain_registers
bind imgr_top imgr_monitor i_imgr_monitor (.mclk_in, .rst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .left_pgab_path_unmute_out, .right_pgaa_path_boost_out, .left_loop_gain_sel_out,
  .right_line2_gain_sel_out, .left_voice_to_mux_gain_sel_out, .left_adc_source_mux_out);
